/* File: design/mfd_core.sv */
// Four-phase execute core with field decode and AXI4-Lite registers
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module mfd_core
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  output logic o_instr_ready,
  output logic [3:0] o_phase,
  output logic o_cycle_nop,
  output logic o_skip_pending,
  input mfd_pkg::mfd_axi_req_s i_axi,
  output mfd_pkg::mfd_axi_rsp_s o_axi
);
  import mfd_pkg::*;

  typedef struct packed {
    mfd_phase_e phase;
    logic [15:0] instr;
    logic nop_cycle;
    logic skip_pend;
    logic second_pend;
    logic run;
    logic [7:0] work;
    logic [7:0] bank;
    logic [NFLAGS-1:0] flags;
    logic [TABLE_PTR_W-1:0] table_ptr;
    logic [7:0] tblat;
    logic [7:0] prod_lo;
    logic [7:0] prod_hi;
    logic [7:0] alu;
    logic [7:0] sh_work;
    logic [NFLAGS-1:0] sh_flags;
    logic [7:0] sh_bank;
    logic [RAM_AW-1:0] ram_addr;
    logic [7:0] ram_wd;
    logic ram_we;
    logic [31:0] decode;
    logic aw_held;
    logic [AXI_AW-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mfd_core_state_s;

  mfd_core_state_s s_r;
  mfd_core_state_s s_nxt;
  mfd_fields_s fld;
  mfd_fields_s in_fld;
  logic [RAM_AW-1:0] rd_addr;
  logic [7:0] rd_data;

  //////////////////////////////////////////////////////////////////////////
  // Field decode of the held word and of the word on offer

  mfd_field_decode u_dec_held
  (
    .i_word(s_r.instr),
    .o_fields(fld)
  );

  mfd_field_decode u_dec_in
  (
    .i_word(i_instr),
    .o_fields(in_fld)
  );

  // Access bank or bank-selected address
  always_comb
  begin
    if (!fld.access_sel)
      rd_addr = (fld.file8 < ACCESS_SPLIT) ? {ACCESS_LO_BANK, fld.file8}
        : {ACCESS_HI_BANK, fld.file8};
    else
      rd_addr = {s_r.bank[BANK_W-1:0], fld.file8};
  end

  // Registered read: the Q2 address gives the operand in Q3
  mfd_data_ram #(.AW(RAM_AW), .DW(8)) u_ram
  (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_rd_addr(rd_addr),
    .o_rd_data(rd_data),
    .i_wr_en(s_r.ram_we),
    .i_wr_addr(s_r.ram_addr),
    .i_wr_data(s_r.ram_wd)
  );

  //////////////////////////////////////////////////////////////////////////
  // Register read view

  function automatic logic [32:0] reg_read(input mfd_core_state_s st,
    input logic [AXI_AW-1:0] addr);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    case (addr)
      ADDR_WORK: r[7:0] = st.work;
      ADDR_BANK: r[7:0] = st.bank;
      ADDR_FLAGS: r[NFLAGS-1:0] = st.flags;
      ADDR_TABLE_PTR: r[TABLE_PTR_W-1:0] = st.table_ptr;
      ADDR_TBLAT: r[7:0] = st.tblat;
      ADDR_PROD_LO: r[7:0] = st.prod_lo;
      ADDR_PROD_HI: r[7:0] = st.prod_hi;
      ADDR_RAM_ADDR: r[RAM_AW-1:0] = st.ram_addr;
      ADDR_RAM_DATA: r[7:0] = st.ram_wd;
      ADDR_DECODE: r[31:0] = st.decode;
      ADDR_CORE_STAT: r[6:0] = {st.second_pend, st.skip_pend,
        st.nop_cycle, st.phase};
      ADDR_CTRL: r[0] = st.run;
      default: r = {1'b0, 32'h0000_0000};
    endcase
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Next state: bus slave first, core phases after so the core wins

  always_comb
  begin
    logic [32:0] rd;
    logic [31:0] mask;
    logic [31:0] wv;
    rd = '0;
    mask = '0;
    wv = '0;
    s_nxt = s_r;
    s_nxt.ram_we = 1'b0;
    // Address and data are captured independently
    if (!s_r.aw_held && i_axi.awvalid)
    begin
      s_nxt.aw_held = 1'b1;
      s_nxt.awaddr = i_axi.awaddr;
    end
    if (!s_r.w_held && i_axi.wvalid)
    begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata = i_axi.wdata;
      s_nxt.wstrb = i_axi.wstrb;
    end
    if (s_r.bvalid && i_axi.bready)
      s_nxt.bvalid = 1'b0;
    // Write once both halves are held and no response is pending
    // A new write waits here until the last response has been taken
    if (s_r.aw_held && s_r.w_held && !s_r.bvalid)
    begin
      rd = reg_read(s_r, s_r.awaddr);
      for (int i = 0; i < 4; i++)
        mask[i*8 +: 8] = {8{s_r.wstrb[i]}};
      wv = (rd[31:0] & ~mask) | (s_r.wdata & mask);
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
      case (s_r.awaddr)
        ADDR_WORK: s_nxt.work = wv[7:0];
        ADDR_BANK: s_nxt.bank = wv[7:0];
        ADDR_FLAGS: s_nxt.flags = wv[NFLAGS-1:0];
        ADDR_TABLE_PTR: s_nxt.table_ptr = wv[TABLE_PTR_W-1:0];
        ADDR_TBLAT: s_nxt.tblat = wv[7:0];
        ADDR_PROD_LO: s_nxt.prod_lo = wv[7:0];
        ADDR_PROD_HI: s_nxt.prod_hi = wv[7:0];
        ADDR_RAM_ADDR: s_nxt.ram_addr = wv[RAM_AW-1:0];
        ADDR_RAM_DATA:
        begin
          s_nxt.ram_wd = wv[7:0];
          s_nxt.ram_we = 1'b1;
        end
        ADDR_CTRL: s_nxt.run = wv[0];
        default: s_nxt.run = s_r.run; // Read-only or unmapped
      endcase
    end
    // Read answers on the edge after acceptance
    if (s_r.rvalid && i_axi.rready)
      s_nxt.rvalid = 1'b0;
    if (!s_r.rvalid && i_axi.arvalid)
    begin
      rd = reg_read(s_r, i_axi.araddr);
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd[31:0];
      s_nxt.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
    end

    // Phase sequencer; a discarded word runs all four phases idle
    case (s_r.phase)
      PH_Q1:
      begin
        if (s_r.run && i_instr_valid)
        begin
          s_nxt.instr = i_instr;
          s_nxt.nop_cycle = s_r.skip_pend | s_r.second_pend;
          s_nxt.skip_pend = 1'b0;
          s_nxt.second_pend = s_r.skip_pend && in_fld.two_word;
          s_nxt.phase = PH_Q2;
        end
      end
      PH_Q2:
        s_nxt.phase = PH_Q3;
      PH_Q3:
      begin
        // Process: zero test on the read operand, or ALU work on the working register and literal
        if (!s_r.nop_cycle)
        begin
          if (fld.is_test_skip && rd_data == 8'h00)
            s_nxt.skip_pend = 1'b1;
          if (fld.is_xor_lit)
            s_nxt.alu = s_r.work ^ fld.lit8;
          if (fld.is_mul_lit)
            {s_nxt.prod_hi, s_nxt.prod_lo} = 16'(s_r.work)
              * 16'(fld.lit8);
        end
        s_nxt.phase = PH_Q4;
      end
      PH_Q4:
      begin
        if (!s_r.nop_cycle)
        begin
          s_nxt.decode = {fld.addr12, fld.lit_width, fld.bit_index,
            fld.tbl_mode, fld.fast_shadow, fld.access_sel,
            fld.rel_offset};
          // Write-back; test-skip leaves every flag alone
          if (fld.is_xor_lit)
          begin
            s_nxt.work = s_r.alu;
            s_nxt.flags[FLG_N] = s_r.alu[7];
            s_nxt.flags[FLG_Z] = (s_r.alu == 8'h00);
          end
          if (fld.is_table)
          begin
            case (fld.tbl_mode)
              TBL_POST_INC, TBL_PRE_INC:
                s_nxt.table_ptr = s_r.table_ptr + 21'h00_0001;
              TBL_POST_DEC:
                s_nxt.table_ptr = s_r.table_ptr - 21'h00_0001;
              default:
                s_nxt.table_ptr = s_r.table_ptr;
            endcase
          end
          if (fld.is_call && fld.fast_shadow)
          begin
            s_nxt.sh_work = s_r.work;
            s_nxt.sh_flags = s_r.flags;
            s_nxt.sh_bank = s_r.bank;
          end
          if (fld.is_return && fld.fast_shadow)
          begin
            s_nxt.work = s_r.sh_work;
            s_nxt.flags = s_r.sh_flags;
            s_nxt.bank = s_r.sh_bank;
          end
        end
        s_nxt.phase = PH_Q1;
      end
      default:
        s_nxt.phase = PH_Q1;
    endcase
    // Carry, digit carry and signed wrap move only by bus write or fast return here;
    // the arithmetic forms that drive them are outside this core
  end

  // State register
  // Reset lands in the decode slot with run set, so ready is high at once
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_r <= '0;
      s_r.phase <= PH_Q1;
      s_r.run <= CTRL_RUN_RESET;
    end
    else
      s_r <= s_nxt;
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  // Ready only in the decode slot while running
  assign o_instr_ready = (s_r.phase == PH_Q1) && s_r.run;
  assign o_phase = s_r.phase;
  assign o_cycle_nop = s_r.nop_cycle;
  assign o_skip_pending = s_r.skip_pend;

  // Bus answer straight from held state
  // Ready falls while a half is held, so each half is taken only once
  always_comb
  begin
    o_axi = '0;
    o_axi.awready = !s_r.aw_held;
    o_axi.wready = !s_r.w_held;
    o_axi.bvalid = s_r.bvalid;
    o_axi.bresp = s_r.bresp;
    o_axi.arready = !s_r.rvalid;
    o_axi.rvalid = s_r.rvalid;
    o_axi.rdata = s_r.rdata;
    o_axi.rresp = s_r.rresp;
  end

endmodule // mfd_core

/* File: design/mfd_data_ram.sv */
// File register memory with a registered read port
`timescale 1ns/1ps
module mfd_data_ram
#(
  parameter int AW = 12,
  parameter int DW = 8
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [DW-1:0] o_rd_data,
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [DW-1:0] i_wr_data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Storage has no reset; contents are undefined until written
  always_ff @(posedge i_ref_clk)
  begin
    if (i_wr_en)
      mem[i_wr_addr] <= i_wr_data;
  end

  // Read data one edge after the address
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      o_rd_data <= '0;
    else
      o_rd_data <= mem[i_rd_addr];
  end

endmodule // mfd_data_ram

/* File: design/mfd_field_decode.sv */
// Opcode field extraction for one instruction word
`timescale 1ns/1ps
module mfd_field_decode
(
  input wire logic [15:0] i_word,
  output mfd_pkg::mfd_fields_s o_fields
);
  import mfd_pkg::*;

  // Pure field slicing and opcode class match
  always_comb
  begin
    o_fields = '0;
    o_fields.access_sel = i_word[A_BIT];
    o_fields.bit_index = i_word[BIT_IDX_LSB +: 3];
    o_fields.tbl_mode = mfd_tbl_mode_e'(i_word[1:0]);
    // Call keeps its fast bit beside the opcode, return at the bottom
    o_fields.fast_shadow = (i_word[15:9] == OPC_CALL) ? i_word[8]
      : i_word[0];
    o_fields.lit8 = i_word[7:0];
    o_fields.file8 = i_word[7:0];
    o_fields.addr12 = i_word[11:0];
    // Offsets: long and short branches signed, others direct
    if (i_word[15:12] == OPC_REL11)
    begin
      o_fields.rel_offset = i_word[10:0];
      o_fields.rel_signed = 1'b1;
    end
    else if (i_word[15:11] == OPC_REL8)
    begin
      o_fields.rel_offset = {{3{i_word[7]}}, i_word[7:0]};
      o_fields.rel_signed = 1'b1;
    end
    else
    begin
      o_fields.rel_offset = {3'h0, i_word[7:0]};
      o_fields.rel_signed = 1'b0;
    end
    // Literal width by class
    if (i_word[15:11] == OPC_LIT8_HI5)
      o_fields.lit_width = LIT_W8;
    else if (i_word[15:8] == OPC_LOAD_FSR)
      o_fields.lit_width = LIT_W12;
    else if (i_word[15:8] == OPC_GOTO || i_word[15:9] == OPC_CALL)
      o_fields.lit_width = LIT_W20;
    else
      o_fields.lit_width = LIT_NONE;
    // Second-word carriers decide the three-cycle skip
    o_fields.two_word = (i_word[15:12] == OPC_MOVE12)
      || (i_word[15:10] == OPC_TWO_HI6);
    o_fields.is_test_skip = (i_word[15:9] == OPC_TEST_SKIP);
    o_fields.is_xor_lit = (i_word[15:8] == OPC_XOR_LIT);
    o_fields.is_mul_lit = (i_word[15:8] == OPC_MUL_LIT);
    o_fields.is_table = (i_word[15:3] == OPC_TABLE);
    o_fields.is_call = (i_word[15:9] == OPC_CALL);
    o_fields.is_return = (i_word[15:1] == OPC_RETURN);
  end

endmodule // mfd_field_decode

/* File: inc/mfd_pkg.sv */
// Shared constants and types for the instruction field decode core
package mfd_pkg;

  // Bus geometry
  localparam int AXI_AW = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register byte offsets
  localparam logic [AXI_AW-1:0] ADDR_WORK = 8'h00;
  localparam logic [AXI_AW-1:0] ADDR_BANK = 8'h04;
  localparam logic [AXI_AW-1:0] ADDR_FLAGS = 8'h08;
  localparam logic [AXI_AW-1:0] ADDR_TABLE_PTR = 8'h0C;
  localparam logic [AXI_AW-1:0] ADDR_TBLAT = 8'h10;
  localparam logic [AXI_AW-1:0] ADDR_PROD_LO = 8'h14;
  localparam logic [AXI_AW-1:0] ADDR_PROD_HI = 8'h18;
  localparam logic [AXI_AW-1:0] ADDR_RAM_ADDR = 8'h1C;
  localparam logic [AXI_AW-1:0] ADDR_RAM_DATA = 8'h20;
  localparam logic [AXI_AW-1:0] ADDR_DECODE = 8'h24;
  localparam logic [AXI_AW-1:0] ADDR_CORE_STAT = 8'h28;
  localparam logic [AXI_AW-1:0] ADDR_CTRL = 8'h2C;

  // Widths
  localparam int TABLE_PTR_W = 21;
  localparam int RAM_AW = 12;
  localparam int BANK_W = 4;
  localparam int NFLAGS = 5;

  // Flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_DIGIT_CARRY = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_SIGNED_WRAP = 3;
  localparam int FLG_N = 4;

  // Reset values
  localparam logic CTRL_RUN_RESET = 1'b1;

  // Access RAM split: low part in bank 0, high part in top bank
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hF;

  // Field positions
  localparam int A_BIT = 8;
  localparam int BIT_IDX_LSB = 9;

  // Opcode patterns
  localparam logic [6:0] OPC_TEST_SKIP = 7'h33;
  localparam logic [7:0] OPC_XOR_LIT = 8'h0A;
  localparam logic [7:0] OPC_MUL_LIT = 8'h0D;
  localparam logic [4:0] OPC_LIT8_HI5 = 5'h01;
  localparam logic [3:0] OPC_REL11 = 4'hD;
  localparam logic [4:0] OPC_REL8 = 5'h1C;
  localparam logic [3:0] OPC_MOVE12 = 4'hC;
  localparam logic [5:0] OPC_TWO_HI6 = 6'h3B;
  localparam logic [7:0] OPC_LOAD_FSR = 8'hEE;
  localparam logic [6:0] OPC_CALL = 7'h76;
  localparam logic [7:0] OPC_GOTO = 8'hEF;
  localparam logic [14:0] OPC_RETURN = 15'h0009;
  localparam logic [12:0] OPC_TABLE = 13'h0001;

  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } mfd_phase_e;

  typedef enum logic [1:0] {
    TBL_KEEP = 2'b00,
    TBL_POST_INC = 2'b01,
    TBL_POST_DEC = 2'b10,
    TBL_PRE_INC = 2'b11
  } mfd_tbl_mode_e;

  typedef enum logic [1:0] {
    LIT_NONE = 2'b00,
    LIT_W8 = 2'b01,
    LIT_W12 = 2'b10,
    LIT_W20 = 2'b11
  } mfd_lit_e;

  typedef struct packed {
    logic access_sel;
    logic [2:0] bit_index;
    mfd_tbl_mode_e tbl_mode;
    logic [10:0] rel_offset;
    logic rel_signed;
    logic fast_shadow;
    mfd_lit_e lit_width;
    logic [7:0] lit8;
    logic [11:0] addr12;
    logic [7:0] file8;
    logic two_word;
    logic is_test_skip;
    logic is_xor_lit;
    logic is_mul_lit;
    logic is_table;
    logic is_call;
    logic is_return;
  } mfd_fields_s;

  typedef struct packed {
    logic awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_AW-1:0] araddr;
    logic rready;
  } mfd_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mfd_axi_rsp_s;

endpackage

/* File: testbench/mcu_instruction_field_decode_tb.sv */
// Self-checking bench for the execute core
`timescale 1ns/1ps
module mcu_instruction_field_decode_tb;
  import mfd_pkg::*;
  typedef struct packed {
    logic [1:0] resp;
    logic [31:0] data;
    logic [31:0] mask;
  } mfd_note_s;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic stall = 1'b0;
  logic [31:0] seed = 32'h15C9;
  mfd_axi_req_s axi = '0;
  mfd_axi_rsp_s rsp;
  logic fvalid, ready, nop, skp;
  logic [15:0] fword;
  logic [3:0] phase;
  int fail_count = 0;
  int checks_done = 0;
  int nops = 0;
  mfd_note_s rq[$];
  logic [1:0] wq[$];
  mfd_note_s n;
  logic [31:0] tbl_exp[4] = '{32'h100, 32'h101, 32'h0FF, 32'h101};
  logic [15:0] dw[9] = '{16'h9F00, 16'h9000, 16'hD7FF, 16'h0013, 16'h0A00,
    16'hED00, 16'hEE10, 16'hC123, 16'hE080};
  logic [31:0] dm[9] = '{32'h38800, 32'h38800, 32'h7FF, 32'h1000, 32'hC0000,
    32'hC1000, 32'hC0000, 32'hFFF0_0000, 32'h7FF};
  logic [31:0] de[9] = '{32'h38800, 32'h0, 32'h7FF, 32'h1000, 32'h40000,
    32'hC1000, 32'h80000, 32'h1230_0000, 32'h780};
  logic [15:0] skw[3] = '{16'h6650, 16'h6750, 16'h6650};
  logic [7:0] w0, k, r;
  logic [15:0] p;
  int n0;

  always #12.5 i_ref_clk = ~i_ref_clk;

  mfd_core i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_instr_valid(fvalid), .i_instr(fword), .o_instr_ready(ready),
    .o_phase(phase), .o_cycle_nop(nop), .o_skip_pending(skp),
    .i_axi(axi), .o_axi(rsp));
  mfd_fetch_model i_fetch (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_ready(ready), .i_stall(stall), .o_valid(fvalid), .o_word(fword));

  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Random fetch stalls keep the ready wait honest
  always @(posedge i_ref_clk)
  begin
    seed <= lfsr(seed);
    stall <= &seed[2:1];
  end
  task fail(input string m);
    fail_count++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask
  task conclude;
    if (fail_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Negedge view equals what the next edge sees, so no race
  always @(negedge i_ref_clk)
  begin
    // One count per discarded instruction cycle, fetch stalls aside
    if (nop === 1'b1 && phase === PH_Q4)
      nops++;
    if (rsp.rvalid && axi.rready)
    begin
      n = rq.pop_front();
      checks_done++;
      if ((rsp.rdata & n.mask) !== n.data || rsp.rresp !== n.resp)
        fail("read value or response wrong");
    end
    if (rsp.bvalid && axi.bready)
    begin
      checks_done++;
      if (rsp.bresp !== wq.pop_front())
        fail("write response wrong");
    end
  end
  // One AXI4-Lite transfer, held until each channel is taken
  task bus(input bit w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] m, input logic [1:0] rs);
    bit ta, tw, tr, tb;
    @(posedge i_ref_clk);
    if (w)
    begin
      wq.push_back(rs);
      axi.awvalid <= 1'b1;
      axi.awaddr <= a;
      axi.wvalid <= 1'b1;
      axi.wdata <= d;
      axi.wstrb <= 4'hF;
      axi.bready <= 1'b1;
    end
    else
    begin
      rq.push_back(mfd_note_s'{rs, d, m});
      axi.arvalid <= 1'b1;
      axi.araddr <= a;
      axi.rready <= 1'b1;
    end
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge i_ref_clk);
      ta = axi.awvalid && rsp.awready;
      tw = axi.wvalid && rsp.wready;
      tr = axi.arvalid && rsp.arready;
      tb = (rsp.bvalid && axi.bready) || (rsp.rvalid && axi.rready);
      @(posedge i_ref_clk);
      if (ta) axi.awvalid <= 1'b0;
      if (tw) axi.wvalid <= 1'b0;
      if (tr) axi.arvalid <= 1'b0;
      if (tb)
      begin
        axi.bready <= 1'b0;
        axi.rready <= 1'b0;
      end
    end
  endtask
  // Wait until every queued word has run to the end of its cycle
  task settle;
    for (int i = 0; i < 400; i++)
    begin
      @(negedge i_ref_clk);
      if (i_fetch.q.size() == 0 && !fvalid && phase === PH_Q1)
        break;
    end
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    bus(1'b0, ADDR_CTRL, 32'h1, '1, RESP_OKAY);
    bus(1'b0, 8'h30, '0, '1, RESP_SLVERR);
    bus(1'b1, 8'h30, 32'h5, '0, RESP_SLVERR);
    bus(1'b1, ADDR_TABLE_PTR, '1, '0, RESP_OKAY);
    bus(1'b0, ADDR_TABLE_PTR, 32'h1F_FFFF, '1, RESP_OKAY);
    for (int m = 0; m < 4; m++)
    begin
      bus(1'b1, ADDR_TABLE_PTR, 32'h100, '0, RESP_OKAY);
      i_fetch.push(16'h0008 | 16'(m));
      settle();
      bus(1'b0, ADDR_TABLE_PTR, tbl_exp[m], '1, RESP_OKAY);
      bus(1'b0, ADDR_DECODE, 32'(m) << 13, 32'h6000, RESP_OKAY);
    end
    for (int i = 0; i < 9; i++)
    begin
      i_fetch.push(dw[i]);
      settle();
      bus(1'b0, ADDR_DECODE, de[i], dm[i], RESP_OKAY);
    end
    // Fast call saves the working register, only fast return restores it
    bus(1'b1, ADDR_WORK, 32'h5A, '0, RESP_OKAY);
    i_fetch.push(16'hED00);
    settle();
    bus(1'b1, ADDR_WORK, 32'hA5, '0, RESP_OKAY);
    i_fetch.push(16'h0012);
    settle();
    bus(1'b0, ADDR_WORK, 32'hA5, '1, RESP_OKAY);
    i_fetch.push(16'h0013);
    settle();
    bus(1'b0, ADDR_WORK, 32'h5A, '1, RESP_OKAY);
    // Literal XOR, first pass forces a zero result
    for (int i = 0; i < 6; i++)
    begin
      w0 = seed[7:0];
      k = (i == 0) ? w0 : seed[15:8];
      r = w0 ^ k;
      bus(1'b1, ADDR_WORK, 32'(w0), '0, RESP_OKAY);
      bus(1'b1, ADDR_FLAGS, 32'h0B, '0, RESP_OKAY);
      i_fetch.push({8'h0A, k});
      settle();
      bus(1'b0, ADDR_WORK, 32'(r), '1, RESP_OKAY);
      bus(1'b0, ADDR_FLAGS, {27'h0, r[7], 1'b1, r == 8'h00, 2'h3},
        '1, RESP_OKAY);
    end
    w0 = seed[7:0];
    k = seed[15:8];
    p = {8'h00, w0} * {8'h00, k};
    bus(1'b1, ADDR_WORK, 32'(w0), '0, RESP_OKAY);
    i_fetch.push({8'h0D, k});
    settle();
    bus(1'b0, ADDR_PROD_LO, 32'(p[7:0]), '1, RESP_OKAY);
    bus(1'b0, ADDR_PROD_HI, 32'(p[15:8]), '1, RESP_OKAY);
    // Zero in access bank 0x050, nonzero in bank 2 at 0x250
    bus(1'b1, ADDR_RAM_ADDR, 32'h050, '0, RESP_OKAY);
    bus(1'b1, ADDR_RAM_DATA, 32'h00, '0, RESP_OKAY);
    bus(1'b1, ADDR_RAM_ADDR, 32'h250, '0, RESP_OKAY);
    bus(1'b1, ADDR_RAM_DATA, 32'h33, '0, RESP_OKAY);
    bus(1'b1, ADDR_BANK, 32'h2, '0, RESP_OKAY);
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, ADDR_WORK, '0, '0, RESP_OKAY);
      n0 = nops;
      i_fetch.push(skw[i]);
      if (i == 2)
        i_fetch.push(16'hC123);
      i_fetch.push(16'h0AF0);
      i_fetch.push(16'h0A0F);
      settle();
      bus(1'b0, ADDR_WORK, (i == 1) ? 32'hFF : 32'h0F, '1, RESP_OKAY);
      checks_done++;
      if (nops - n0 != ((i == 0) ? 1 : (i == 1) ? 0 : 2))
        fail("discarded cycle count wrong");
    end
    conclude();
  end

  // Watchdog well beyond the expected few hundred cycles
  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    fail_count++;
    conclude();
  end
endmodule // mcu_instruction_field_decode_tb

/* File: testbench/mfd_core_properties.sv */
// Concurrent checks on the execute core ports
`timescale 1ns/1ps
module mfd_core_properties
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic o_instr_ready,
  input wire logic [3:0] o_phase,
  input wire logic o_cycle_nop,
  input wire logic o_skip_pending,
  input mfd_pkg::mfd_axi_req_s i_axi,
  input mfd_pkg::mfd_axi_rsp_s o_axi
);
  import mfd_pkg::*;
  logic take;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // Word accepted by the core this cycle
  assign take = i_instr_valid && o_instr_ready;
  ////////////////////////////////////////////////////////////
  // Core phases
  AST_READY_Q1: assert property (o_instr_ready |-> o_phase == PH_Q1)
    else $error("ready outside first phase");
  AST_PHASE_WALK: assert property (take |=> o_phase == PH_Q2
    ##1 o_phase == PH_Q3 ##1 o_phase == PH_Q4 ##1 o_phase == PH_Q1)
    else $error("phase walk broken");
  AST_PHASE_IDLE: assert property (o_phase == PH_Q1 && !take
    |=> o_phase == PH_Q1) else $error("phase moved without a word");
  AST_SKIP_DISCARD: assert property (o_skip_pending && take
    |=> o_cycle_nop [*4]) else $error("skipped word not discarded");
  AST_NOP_CAUSE: assert property ($rose(o_cycle_nop)
    |-> $past(o_skip_pending && take)) else $error("nop without skip");
  AST_SKIP_AT_Q4: assert property ($rose(o_skip_pending)
    |-> o_phase == PH_Q4) else $error("skip flag set off cycle end");
  // Register bus answers
  AST_READ_ANSWER: assert property (i_axi.arvalid && o_axi.arready
    |=> o_axi.rvalid) else $error("read not answered");
  AST_RDATA_HOLD: assert property (o_axi.rvalid && !i_axi.rready
    |=> o_axi.rvalid && $stable(o_axi.rdata)) else $error("rdata moved");
  AST_WRITE_ANSWER: assert property (i_axi.awvalid && o_axi.awready
    && i_axi.wvalid && o_axi.wready |-> ##2 o_axi.bvalid)
    else $error("write not answered");
endmodule // mfd_core_properties

bind mfd_core mfd_core_properties i_props (.i_ref_clk(i_ref_clk),
  .i_rst(i_rst), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
  .o_instr_ready(o_instr_ready), .o_phase(o_phase),
  .o_cycle_nop(o_cycle_nop), .o_skip_pending(o_skip_pending),
  .i_axi(i_axi), .o_axi(o_axi));

/* File: testbench/mfd_fetch_model.sv */
// Fetch-stage stand-in that hands instruction words to the core
`timescale 1ns/1ps
module mfd_fetch_model
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ready,
  input wire logic i_stall,
  output logic o_valid,
  output logic [15:0] o_word
);
  logic [15:0] q[$];
  logic valid_r = 1'b0;
  logic [15:0] word_r = 16'h0000;
  assign o_valid = valid_r;
  assign o_word = word_r;
  // Bench queues words here in program order
  task push(input logic [15:0] w);
    q.push_back(w);
  endtask
  // Hold an offered word until taken; idle lines wander, never stale
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      valid_r <= 1'b0;
    else if (!valid_r || i_ready)
    begin
      valid_r <= 1'b0;
      word_r <= ~word_r;
      if (q.size() > 0 && !i_stall)
      begin
        valid_r <= 1'b1;
        word_r <= q.pop_front();
      end
    end
  end
endmodule // mfd_fetch_model
